// ==== bench/clock_setup_assertions.sv ====
`timescale 1ns/100ps
module clock_setup_assertions
  import clock_setup_pkg::*;
#(
  parameter int VERIFY_LIMIT = VERIFY_CYCLES
) (
  input logic       CLK_SYS,
  input logic       SYS_RST,
  input logic       CE,
  input logic       AWVALID,
  input logic       AWREADY,
  input logic       WVALID,
  input logic       WREADY,
  input logic       BVALID,
  input logic       BREADY,
  input logic       ARVALID,
  input logic       ARREADY,
  input logic       RVALID,
  input logic       RREADY,
  input logic [1:0] OSC_SELECT,
  input logic       PLL_POWER_DOWN,
  input logic       PLL_DRIVE_ON,
  input logic       PLL_NORMAL,
  input logic       SYS_FROM_OSC,
  input logic [1:0] PLL_OUTPUT_DIVIDER,
  input logic [8:0] PLL_FEEDBACK,
  input logic [4:0] PLL_REFERENCE,
  input logic       IRQ
);
  // ---------------------------------------------------------------
  // one clock domain, reset masks every check
  // ---------------------------------------------------------------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  // response lands two edges after both halves are taken
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY
    && CE |-> ##2 BVALID) else $error("write response missing");
  a_read_answer: assert property (ARVALID && ARREADY && CE |=> RVALID)
    else $error("read data missing");
  a_bvalid_drop: assert property (BVALID && BREADY && CE |=> !BVALID)
    else $error("write response repeated");
  a_rvalid_drop: assert property (RVALID && RREADY && CE |=> !RVALID)
    else $error("read data repeated");
  a_aw_refused: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write accepted during response");
  a_ar_refused: assert property (RVALID |-> !ARREADY)
    else $error("read accepted during data");
  // power-off wins over the drive bit
  a_pll_mode: assert property (PLL_NORMAL |-> !PLL_POWER_DOWN)
    else $error("normal mode while powered down");
  a_drive_mirror: assert property (PLL_DRIVE_ON == PLL_NORMAL)
    else $error("drive enable differs from normal mode");
  // reset loads setup defaults and the code 0xb translation
  a_reset_load: assert property ($past(SYS_RST) |->
    PLL_POWER_DOWN && SYS_FROM_OSC && OSC_SELECT == 2'h0
    && PLL_FEEDBACK == 9'h041) else $error("reset values wrong");
  a_lookup_fixed: assert property (PLL_REFERENCE == 5'h00
    && PLL_OUTPUT_DIVIDER == 2'h0) else $error("lookup fields wrong");

  c_write: cover property (BVALID && BREADY);
  c_read: cover property (RVALID && RREADY);
  c_irq: cover property ($rose(IRQ));
endmodule : clock_setup_assertions

bind clock_setup clock_setup_assertions #(.VERIFY_LIMIT(VERIFY_LIMIT))
  u_chk (.*);

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  // ---------------------------------------------------------------
  // design ports, same names so the instance connects by name
  // ---------------------------------------------------------------
  logic CLK_SYS, SYS_RST, CE, AWVALID, AWREADY, WVALID, WREADY;
  logic BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY, IRQ;
  logic MAIN_OSC_BEAT, INT_OSC_BEAT, PLL_BEAT, MAIN_OSC_OFF;
  logic INT_OSC_OFF, PLL_POWER_DOWN, PLL_DRIVE_ON, PLL_NORMAL;
  logic SYS_FROM_OSC;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd_data;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, OSC_SELECT, PLL_OUTPUT_DIVIDER, resp;
  logic [8:0]  PLL_FEEDBACK;
  logic [4:0]  PLL_REFERENCE;
  logic        beat_on; // heartbeats toggle while high
  int          bad_count, samples_checked, cyc;
  // expected feedback per crystal code
  logic [8:0] fb [16] = '{9'h0, 9'h0, 9'h0, 9'h0, 9'h06e, 9'h06b,
    9'h062, 9'h060, 9'h04f, 9'h04e, 9'h04c, 9'h041, 9'h03f, 9'h034,
    9'h030, 9'h02f};

  // short silence limit keeps fault runs brief
  clock_setup #(.VERIFY_LIMIT(16)) DUT (.*);

  always #5 CLK_SYS = ~CLK_SYS;
  // live clocks toggle their heartbeat every fourth cycle, so each
  // level stands long enough for two synchroniser stages to agree
  always @(posedge CLK_SYS) if (beat_on && cyc[1:0] == 2'h0) begin
    {MAIN_OSC_BEAT, INT_OSC_BEAT, PLL_BEAT} <=
      ~{MAIN_OSC_BEAT, INT_OSC_BEAT, PLL_BEAT};
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // wide enough for a response code or flag packed above a data word
  task automatic chk(input string n, input logic [63:0] s, e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // both halves offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1;
    WVALID <= 1;
    while (!(aw && w)) begin
      @(posedge CLK_SYS);
      if (!aw && AWREADY) begin
        aw = 1;
        AWVALID <= 0;
      end
      if (!w && WREADY) begin
        w = 1;
        WVALID <= 0;
      end
    end
    do @(posedge CLK_SYS); while (!BVALID);
    resp = BRESP;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    ARADDR <= a;
    ARVALID <= 1;
    do @(posedge CLK_SYS); while (!ARREADY);
    ARVALID <= 0;
    do @(posedge CLK_SYS); while (!RVALID);
    rd_data = RDATA;
    resp = RRESP;
  endtask : rd

  task automatic t_reset;
    rd(12'h060);
    chk("setup", rd_data, 32'h3ac0);
    rd(12'h064);
    chk("readback", rd_data, 32'h0820);
    chk("irq", IRQ, 1'b0);
  endtask : t_reset

  task automatic t_bus;
    rd(12'h070);
    chk("unmapped", {resp, rd_data}, {2'h2, 32'h0});
    wr(12'h070, 32'h1);
    chk("unmapped wr", resp, 2'h2);
    wr(12'h064, 32'hffffffff);
    rd(12'h064);
    chk("ro readback", {resp, rd_data}, {2'h0, 32'h0820});
    wr(12'h060, 32'hffffffff);
    rd(12'h060);
    chk("setup width", rd_data, 32'h3fff);
    rd(12'h064);
    chk("code f", rd_data, 32'h05e0);
  endtask : t_bus

  task automatic t_crystal;
    for (int c = 0; c < 16; c++) begin
      // pll stays powered off so codes 0..3 are legal
      wr(12'h060, 32'h3000 | (c << 6));
      rd(12'h064);
      chk("readback", rd_data, {18'h0, fb[c], 5'h0});
      chk("feedback", PLL_FEEDBACK, fb[c]);
      chk("div ref", {PLL_OUTPUT_DIVIDER, PLL_REFERENCE}, 7'h0);
    end
  endtask : t_crystal

  task automatic t_modes;
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      // crystal 0xb kept; internal/4 is the only running pll source
      v = (i << 12) | (i[0] << 11) | 32'h2c0 | (i << 4) | i;
      wr(12'h060, v);
      repeat (2) @(posedge CLK_SYS);
      chk("pll mode", {PLL_POWER_DOWN, PLL_NORMAL}, {i[1], i == 0});
      chk("osc sel", OSC_SELECT, i);
      chk("offs", {INT_OSC_OFF, MAIN_OSC_OFF}, i);
      chk("bypass", SYS_FROM_OSC, i[0]);
      chk("drive", PLL_DRIVE_ON, i == 0);
    end
  endtask : t_modes

  task automatic t_verify;
    wr(12'h06c, 32'h7);
    wr(12'h060, 32'h3ecc);
    repeat (60) @(posedge CLK_SYS);
    rd(12'h068);
    chk("live", {IRQ, rd_data}, 33'h0);
    beat_on <= 0;
    repeat (40) @(posedge CLK_SYS);
    chk("irq", IRQ, 1'b1);
    rd(12'h068);
    chk("faults", rd_data, 32'h7);
    wr(12'h06c, 32'h0);
    repeat (2) @(posedge CLK_SYS);
    chk("masked", IRQ, 1'b0);
    wr(12'h060, 32'h3ac0);
    wr(12'h068, 32'h7);
    wr(12'h06c, 32'h7);
    repeat (40) @(posedge CLK_SYS);
    rd(12'h068);
    chk("off", {IRQ, rd_data}, 33'h0);
    // clock enable low must freeze the timers with the beats silent
    wr(12'h060, 32'h3ecc);
    CE <= 0;
    repeat (40) @(posedge CLK_SYS);
    chk("frozen", IRQ, 1'b0);
    CE <= 1;
    repeat (40) @(posedge CLK_SYS);
    chk("thawed", IRQ, 1'b1);
  endtask : t_verify

  task automatic finish_test;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    {CLK_SYS, AWVALID, WVALID, ARVALID, AWADDR, ARADDR, WDATA} = '0;
    {MAIN_OSC_BEAT, INT_OSC_BEAT, PLL_BEAT} = 3'h0;
    {SYS_RST, CE, BREADY, RREADY, beat_on} = 5'h1f;
    WSTRB = 4'hf;
    bad_count = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (2) @(posedge CLK_SYS);
    SYS_RST <= 0;
    @(posedge CLK_SYS);
    t_reset();
    t_bus();
    t_crystal();
    t_modes();
    t_verify();
    finish_test();
  end
endmodule : tb_top

// ==== design/clock_setup.sv ====
`timescale 1ns/100ps
module clock_setup
  import clock_setup_pkg::*;
#(
  parameter int VERIFY_LIMIT = VERIFY_CYCLES
) (
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic        CE,
  // axi4-lite slave
  input  wire logic [11:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [11:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // heartbeats from the watched clocks, asynchronous
  input  wire logic        MAIN_OSC_BEAT,
  input  wire logic        INT_OSC_BEAT,
  input  wire logic        PLL_BEAT,
  // clock tree controls
  output logic [1:0]       OSC_SELECT,
  output logic             MAIN_OSC_OFF,
  output logic             INT_OSC_OFF,
  output logic             PLL_POWER_DOWN,
  output logic             PLL_DRIVE_ON,
  output logic             PLL_NORMAL,
  output logic             SYS_FROM_OSC,
  output logic [1:0]       PLL_OUTPUT_DIVIDER,
  output logic [8:0]       PLL_FEEDBACK,
  output logic [4:0]       PLL_REFERENCE,
  output logic             IRQ
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam int CNT_W = $clog2(VERIFY_LIMIT + 1);

  typedef struct packed {
    logic [RCC_W-1:0]      run_clock_setup;       // run clock setup
    logic [READBACK_W-1:0] readback;  // translated pll values
    logic [EVT_W-1:0]      status;    // sticky fault events
    logic [EVT_W-1:0]      mask;      // interrupt enables
    logic                  irq;
    logic                  pll_normal;
    logic [EVT_W-1:0]      sync1;     // beat synchroniser stages
    logic [EVT_W-1:0]      sync2;
    logic [EVT_W-1:0]      sync3;
    logic [EVT_W-1:0]      beat;      // filtered beat level
    logic [EVT_W-1:0][CNT_W-1:0] quiet; // cycles since last beat
    logic                  aw_held;
    logic                  w_held;
    logic [11:0]           awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // crystal code to {divider, feedback, reference}; aims at 200 mhz
  // with reference 0, so osc * (f + 2) / 2 lands near that figure
  // fixed code lookup
  function automatic logic [READBACK_W-1:0] translate(
    input logic [CRYSTAL_W-1:0] code
  );
    logic [FEEDBACK_W-1:0] fb;
    fb = 9'h000;
    case (code)
      4'h4:    fb = 9'h06e;
      4'h5:    fb = 9'h06b;
      4'h6:    fb = 9'h062;
      4'h7:    fb = 9'h060;
      4'h8:    fb = 9'h04f;
      4'h9:    fb = 9'h04e;
      4'ha:    fb = 9'h04c;
      4'hb:    fb = 9'h041;
      4'hc:    fb = 9'h03f;
      4'hd:    fb = 9'h034;
      4'he:    fb = 9'h030;
      4'hf:    fb = 9'h02f;
      // codes 0-3 are not usable with the pll: all fields zero
      default: fb = 9'h000;
    endcase
    // rate set by feedback and reference
    translate = {2'h0, fb, 5'h00};
  endfunction : translate

  // true when the address names a register of this block
  function automatic logic mapped(input logic [11:0] addr);
    if (addr == RUN_CLOCK_SETUP_ADDR) begin
      mapped = 1'b1;
    end else if (addr == PLL_SETTING_READBACK_ADDR) begin
      mapped = 1'b1;
    end else if (addr == CLOCK_EVENT_STATUS_ADDR) begin
      mapped = 1'b1;
    end else if (addr == CLOCK_EVENT_MASK_ADDR) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  endfunction : mapped

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? data[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  logic [EVT_W-1:0] beat_in;   // raw asynchronous beats
  logic [EVT_W-1:0] check_on;  // verification enables
  logic [EVT_W-1:0] fault;     // one-cycle fault events
  logic [EVT_W-1:0] w1c;       // status bits cleared by software
  logic [31:0]      wword;     // merged write word
  logic             do_write;  // address and data both held

  assign beat_in = {PLL_BEAT, INT_OSC_BEAT, MAIN_OSC_BEAT};

  // one process builds the whole next state
  always_comb begin
    state_next = state_reg;
    fault      = '0;
    w1c        = '0;
    wword      = 32'h0000_0000;
    do_write   = 1'b0;

    check_on[EVT_PLL]  = state_reg.run_clock_setup[PLL_CHECK_BIT];
    check_on[EVT_INT]  = state_reg.run_clock_setup[INT_CHECK_BIT];
    check_on[EVT_MAIN] = state_reg.run_clock_setup[MAIN_CHECK_BIT];

    // three-stage synchroniser; only stage two reads stage one
    state_next.sync1 = beat_in;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;

    // a beat counts once stages two and three agree on a new level;
    // a silent source raises one fault per timeout, then restarts
    for (int i = 0; i < EVT_W; i++) begin
      if (!check_on[i]) begin
        // timer idle while its check is off
        state_next.quiet[i] = '0;
      end else if (state_reg.sync2[i] == state_reg.sync3[i] &&
                   state_reg.sync2[i] != state_reg.beat[i]) begin
        state_next.quiet[i] = '0;
      end else if (state_reg.quiet[i] == CNT_W'(VERIFY_LIMIT - 1)) begin
        state_next.quiet[i] = '0;
        fault[i]            = 1'b1;
      end else begin
        state_next.quiet[i] = state_reg.quiet[i] + CNT_W'(1);
      end
      if (state_reg.sync2[i] == state_reg.sync3[i]) begin
        state_next.beat[i] = state_reg.sync2[i];
      end
    end

    // --- write channel: address and data accepted in either order
    if (AWVALID && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.awaddr  = AWADDR;
    end
    if (WVALID && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.wdata  = WDATA;
      state_next.wstrb  = WSTRB;
    end
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
      do_write           = 1'b1;
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = mapped(state_reg.awaddr) ? RESP_OKAY
                                                    : RESP_SLVERR;
    end
    if (state_reg.bvalid && BREADY) begin
      state_next.bvalid = 1'b0;
    end

    // register writes; readback is read-only and ignores writes
    if (do_write) begin
      if (state_reg.awaddr == RUN_CLOCK_SETUP_ADDR) begin
        wword = merge({18'h0, state_reg.run_clock_setup}, state_reg.wdata,
                      state_reg.wstrb);
        state_next.run_clock_setup = wword[RCC_W-1:0];
      end else if (state_reg.awaddr == CLOCK_EVENT_MASK_ADDR) begin
        wword = merge({29'h0, state_reg.mask}, state_reg.wdata,
                      state_reg.wstrb);
        state_next.mask = wword[EVT_W-1:0];
      end else if (state_reg.awaddr == CLOCK_EVENT_STATUS_ADDR) begin
        wword = merge(32'h0, state_reg.wdata, state_reg.wstrb);
        w1c   = wword[EVT_W-1:0];
      end
    end

    // sticky events; a fault in the clearing cycle survives
    state_next.status = (state_reg.status & ~w1c) | fault;
    state_next.irq    = |(state_next.status & state_next.mask);

    state_next.readback =
      translate(state_next.run_clock_setup[CRYSTAL_LSB +: CRYSTAL_W]);
    // normal only with power-off and drive bits both clear
    state_next.pll_normal = !state_next.run_clock_setup[POWER_OFF_BIT] &&
                            !state_next.run_clock_setup[DRIVE_ENABLE_BIT];

    // --- read channel: one read at a time
    if (ARVALID && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      if (ARADDR == RUN_CLOCK_SETUP_ADDR) begin
        state_next.rdata = {18'h0, state_reg.run_clock_setup};
      end else if (ARADDR == PLL_SETTING_READBACK_ADDR) begin
        state_next.rdata = {16'h0, state_reg.readback};
      end else if (ARADDR == CLOCK_EVENT_STATUS_ADDR) begin
        state_next.rdata = {29'h0, state_reg.status};
      end else if (ARADDR == CLOCK_EVENT_MASK_ADDR) begin
        state_next.rdata = {29'h0, state_reg.mask};
      end else begin
        state_next.rdata = 32'h0000_0000;
      end
    end else if (state_reg.rvalid && RREADY) begin
      state_next.rvalid = 1'b0;
    end

    // readies registered so the ports come from flops; a taken
    // channel stays closed until its response has gone
    state_next.awready = !state_next.aw_held && !state_next.bvalid;
    state_next.wready  = !state_next.w_held && !state_next.bvalid;
    state_next.arready = !state_next.rvalid;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // synchronous reset; clock enable low freezes everything
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_reg <= '0;
      // crystal code resets to 6 mhz
      state_reg.run_clock_setup        <= RCC_RESET;
      state_reg.readback   <= translate(RCC_RESET[CRYSTAL_LSB +:
                                                  CRYSTAL_W]);
      state_reg.awready    <= 1'b1;
      state_reg.wready     <= 1'b1;
      state_reg.arready    <= 1'b1;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign AWREADY = state_reg.awready;
  assign WREADY  = state_reg.wready;
  assign BVALID  = state_reg.bvalid;
  assign BRESP   = state_reg.bresp;
  assign ARREADY = state_reg.arready;
  assign RVALID  = state_reg.rvalid;
  assign RRESP   = state_reg.rresp;
  assign RDATA   = state_reg.rdata;
  assign IRQ     = state_reg.irq;

  assign OSC_SELECT     = state_reg.run_clock_setup[OSC_SELECT_LSB +: OSC_SELECT_W];
  assign MAIN_OSC_OFF   = state_reg.run_clock_setup[MAIN_OFF_BIT];
  assign INT_OSC_OFF    = state_reg.run_clock_setup[INT_OFF_BIT];
  assign PLL_POWER_DOWN = state_reg.run_clock_setup[POWER_OFF_BIT];
  assign PLL_DRIVE_ON   = state_reg.pll_normal;
  assign PLL_NORMAL     = state_reg.pll_normal;
  assign SYS_FROM_OSC   = state_reg.run_clock_setup[BYPASS_BIT];
  assign PLL_OUTPUT_DIVIDER =
    state_reg.readback[DIVIDER_LSB +: DIVIDER_W];
  // feedback and reference to the pll
  assign PLL_FEEDBACK   = state_reg.readback[FEEDBACK_LSB +: FEEDBACK_W];
  assign PLL_REFERENCE  = state_reg.readback[REFERENCE_W-1:0];

endmodule : clock_setup

// ==== design/clock_setup_pkg.sv ====
package clock_setup_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] RUN_CLOCK_SETUP_ADDR      = 12'h060;
  localparam logic [11:0] PLL_SETTING_READBACK_ADDR = 12'h064;
  localparam logic [11:0] CLOCK_EVENT_STATUS_ADDR   = 12'h068;
  localparam logic [11:0] CLOCK_EVENT_MASK_ADDR     = 12'h06c;

  // ---------------------------------------------------------------
  // run clock setup fields
  // ---------------------------------------------------------------
  localparam int RCC_W            = 14;
  localparam int POWER_OFF_BIT    = 13;
  localparam int DRIVE_ENABLE_BIT = 12;
  localparam int BYPASS_BIT       = 11;
  localparam int PLL_CHECK_BIT    = 10;
  localparam int CRYSTAL_LSB      = 6;
  localparam int CRYSTAL_W        = 4;
  localparam int OSC_SELECT_LSB   = 4;
  localparam int OSC_SELECT_W     = 2;
  localparam int INT_CHECK_BIT    = 3;
  localparam int MAIN_CHECK_BIT   = 2;
  localparam int INT_OFF_BIT      = 1;
  localparam int MAIN_OFF_BIT     = 0;
  // power-off, drive and bypass set, crystal code 0xb
  localparam logic [RCC_W-1:0] RCC_RESET = 14'h3ac0;

  // ---------------------------------------------------------------
  // readback fields
  // ---------------------------------------------------------------
  localparam int DIVIDER_LSB   = 14;
  localparam int DIVIDER_W     = 2;
  localparam int FEEDBACK_LSB  = 5;
  localparam int FEEDBACK_W    = 9;
  localparam int REFERENCE_W   = 5;
  localparam int READBACK_W    = 16;

  // ---------------------------------------------------------------
  // event bits (status and mask share this layout)
  // ---------------------------------------------------------------
  localparam int EVT_MAIN = 0;
  localparam int EVT_INT  = 1;
  localparam int EVT_PLL  = 2;
  localparam int EVT_W    = 3;

  // ---------------------------------------------------------------
  // bus answers and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS       = 10;
  localparam int VERIFY_TIMEOUT_NS   = 10000;
  localparam int VERIFY_CYCLES       = VERIFY_TIMEOUT_NS / CLK_PERIOD_NS;

endpackage : clock_setup_pkg
